// >>> verilog/pts_time_switch.sv
// Periodic time switch with an APB register file and a seconds calendar.
`timescale 1ns/1ns
module pts_time_switch #(
  parameter int TICKS = pts_pkg::TICKS_PER_SEC
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pts_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Binary process value for the formula stage.
  output logic switch_out
);

  pts_pkg::pts_state_type s;
  pts_pkg::pts_state_type next_s;
  logic tick;

  // Seconds time base.
  pts_tick #(
    .TICKS(TICKS)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(tick)
  );

  // True when time a lies strictly before time b.
  function automatic logic is_before(input logic [pts_pkg::DAY_W-1:0] day_a,
                                     input logic [pts_pkg::SOD_W-1:0] sod_a,
                                     input logic [pts_pkg::DAY_W-1:0] day_b,
                                     input logic [pts_pkg::SOD_W-1:0] sod_b);
    is_before = (day_a < day_b) || ((day_a == day_b) && (sod_a < sod_b));
  endfunction : is_before

  // True when a written value lies within the inclusive range lo to hi.
  function automatic logic in_range(input logic [31:0] value, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (value >= lo) && (value <= hi);
  endfunction : in_range

  // Read value and write legality of one address, both decided in setup.
  function automatic logic [32:0] decode(input pts_pkg::pts_state_type st,
                                         input logic [pts_pkg::ADDR_W-1:0] addr,
                                         input logic wr,
                                         input logic [31:0] wdata);
    logic bad;
    logic [31:0] rd;
    bad = 1'b0;
    rd = 32'h00000000;
    unique case (addr)
      pts_pkg::OFS_CTRL: begin
        rd = {31'h00000000, st.enable};
      end
      pts_pkg::OFS_START_DAY: begin
        rd = {16'h0000, st.start_day};
        bad = wr && !in_range(wdata, 32'h00000000, pts_pkg::LAST_DAY);
      end
      pts_pkg::OFS_START_SOD: begin
        rd = {15'h0000, st.start_sod};
        bad = wr && !in_range(wdata, 32'h00000000, pts_pkg::LAST_SOD);
      end
      pts_pkg::OFS_DURATION: begin
        rd = {8'h00, st.duration};
        bad = wr && !in_range(wdata, pts_pkg::MIN_SPAN, pts_pkg::MAX_SPAN);
      end
      pts_pkg::OFS_PERIOD: begin
        rd = {8'h00, st.period};
        bad = wr && !in_range(wdata, pts_pkg::MIN_SPAN, pts_pkg::MAX_SPAN);
      end
      pts_pkg::OFS_STATUS: begin
        rd = {31'h00000000, st.signal};
        bad = wr;
      end
      pts_pkg::OFS_NEXT_DAY: begin
        rd = {16'h0000, st.next_day};
        bad = wr;
      end
      pts_pkg::OFS_NEXT_SOD: begin
        rd = {15'h0000, st.next_acc[pts_pkg::SOD_W-1:0]};
        bad = wr;
      end
      pts_pkg::OFS_NOW_DAY: begin
        rd = {16'h0000, st.now_day};
        bad = wr && !in_range(wdata, 32'h00000000, pts_pkg::LAST_DAY);
      end
      pts_pkg::OFS_NOW_SOD: begin
        rd = {15'h0000, st.now_sod};
        bad = wr && !in_range(wdata, 32'h00000000, pts_pkg::LAST_SOD);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    decode = {bad, rd};
  endfunction : decode

  // Next-state logic: bus slave, calendar and switch sequencer.
  always_comb begin
    logic [32:0] dec;
    logic commit;
    dec = 33'h000000000;
    commit = 1'b0;
    next_s = s;

    // No wait state: pready rises in the first access cycle.
    next_s.pready = 1'b0;
    if (psel && !penable && !s.pready) begin
      dec = decode(s, paddr, pwrite, pwdata);
      next_s.pready = 1'b1;
      next_s.pslverr = dec[32];
      next_s.prdata = pwrite ? 32'h00000000 : dec[31:0];
    end
    commit = psel && penable && pwrite && s.pready && !s.pslverr;

    // The calendar advances once per second and wraps after the last day.
    if (tick) begin
      if (s.now_sod == pts_pkg::LAST_SOD[pts_pkg::SOD_W-1:0]) begin
        next_s.now_sod = '0;
        if (s.now_day == pts_pkg::LAST_DAY[pts_pkg::DAY_W-1:0]) begin
          next_s.now_day = '0;
        end else begin
          next_s.now_day = s.now_day + 1'b1;
        end
      end else begin
        next_s.now_sod = s.now_sod + 1'b1;
      end
    end

    // Settings take effect at the access edge; a clock write beats the tick.
    if (commit) begin
      unique case (paddr)
        pts_pkg::OFS_CTRL: next_s.enable = pwdata[0];
        pts_pkg::OFS_START_DAY: next_s.start_day = pwdata[pts_pkg::DAY_W-1:0];
        pts_pkg::OFS_START_SOD: next_s.start_sod = pwdata[pts_pkg::SOD_W-1:0];
        pts_pkg::OFS_DURATION: next_s.duration = pwdata[pts_pkg::SPAN_W-1:0];
        pts_pkg::OFS_PERIOD: next_s.period = pwdata[pts_pkg::SPAN_W-1:0];
        pts_pkg::OFS_NOW_DAY: next_s.now_day = pwdata[pts_pkg::DAY_W-1:0];
        pts_pkg::OFS_NOW_SOD: next_s.now_sod = pwdata[pts_pkg::SOD_W-1:0];
        default: begin
        end
      endcase
    end

    // The high time counts down once per second.
    if (tick && (s.remain != '0)) begin
      next_s.remain = s.remain - 1'b1;
    end

    if (!s.enable) begin
      // Disabled: output low, next event parked at the start time.
      next_s.signal = 1'b0;
      next_s.remain = '0;
      next_s.next_day = s.start_day;
      next_s.next_acc = {7'h00, s.start_sod};
      next_s.fsm = pts_pkg::st_idle;
    end else begin
      unique case (s.fsm)
        pts_pkg::st_idle: begin
          if ((s.next_day == s.now_day) &&
              (s.next_acc[pts_pkg::SOD_W-1:0] == s.now_sod)) begin
            // Cycle start: raise the output and schedule the next cycle.
            next_s.signal = 1'b1;
            next_s.remain = s.duration;
            next_s.next_acc = s.next_acc + s.period;
            next_s.fsm = pts_pkg::st_norm;
          end else if (is_before(s.next_day, s.next_acc[pts_pkg::SOD_W-1:0],
                                 s.now_day, s.now_sod)) begin
            // A start in the past is skipped without a pulse.
            next_s.next_acc = s.next_acc + s.period;
            next_s.fsm = pts_pkg::st_norm;
          end else if (s.remain == '0) begin
            next_s.signal = 1'b0;
          end
        end
        pts_pkg::st_norm: begin
          // Fold whole days out of the time of day, one day per cycle.
          if (s.next_acc >= {7'h00, pts_pkg::SEC_PER_DAY}) begin
            next_s.next_acc = s.next_acc - {7'h00, pts_pkg::SEC_PER_DAY};
            next_s.next_day = s.next_day + 1'b1;
          end else begin
            next_s.fsm = pts_pkg::st_idle;
          end
          if (s.remain == '0) begin
            next_s.signal = 1'b0;
          end
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.enable <= pts_pkg::ENABLE_RST;
      s.start_day <= pts_pkg::DAY_RST;
      s.start_sod <= pts_pkg::SOD_RST;
      s.duration <= pts_pkg::SPAN_RST;
      s.period <= pts_pkg::SPAN_RST;
      s.fsm <= pts_pkg::st_idle;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign switch_out = s.signal;

endmodule : pts_time_switch

// >>> verilog/pts_pkg.sv
// Constants, register map and state types of the periodic time switch.
package pts_pkg;

  // Clock rate and the one-second time base derived from it.
  localparam int CLK_PERIOD_NS = 4;
  localparam int SECOND_NS = 1000000000;
  localparam int TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 28;

  // Field widths of dates, times of day, spans and APB addresses.
  localparam int DAY_W = 16;
  localparam int SOD_W = 17;
  localparam int SPAN_W = 24;
  localparam int ADDR_W = 8;

  // Calendar and span limits; day 0 is 01.01.2000, the last day is 31.12.2099.
  localparam logic [SOD_W-1:0] SEC_PER_DAY = 17'h15180;
  localparam logic [31:0] LAST_DAY = 32'h00008EAC;
  localparam logic [31:0] LAST_SOD = 32'h0001517F;
  localparam logic [31:0] MIN_SPAN = 32'h00000003;
  localparam logic [31:0] MAX_SPAN = 32'h0083D600;

  // Register byte offsets on the APB.
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_START_DAY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_START_SOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DURATION = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NEXT_DAY = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NEXT_SOD = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_NOW_DAY = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_NOW_SOD = 8'h24;

  // Reset values of the settings.
  localparam logic ENABLE_RST = 1'b0;
  localparam logic [DAY_W-1:0] DAY_RST = 16'h0000;
  localparam logic [SOD_W-1:0] SOD_RST = 17'h00000;
  localparam logic [SPAN_W-1:0] SPAN_RST = 24'h000003;

  // Sequencer of the next-event time.
  typedef enum logic {
    st_idle,
    st_norm
  } pts_fsm_type;

  // Whole state of the time switch.
  typedef struct packed {
    logic enable;
    logic [DAY_W-1:0] start_day;
    logic [SOD_W-1:0] start_sod;
    logic [SPAN_W-1:0] duration;
    logic [SPAN_W-1:0] period;
    logic [DAY_W-1:0] now_day;
    logic [SOD_W-1:0] now_sod;
    logic [DAY_W-1:0] next_day;
    logic [SPAN_W-1:0] next_acc;
    logic [SPAN_W-1:0] remain;
    logic signal;
    pts_fsm_type fsm;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pts_state_type;

  // Whole state of the one-second tick generator.
  typedef struct packed {
    logic [TICK_W-1:0] count;
    logic tick;
  } pts_tick_state_type;

endpackage : pts_pkg

// >>> verilog/pts_tick.sv
// One-second tick generator for the time switch.
`timescale 1ns/1ns
module pts_tick #(
  parameter int TICKS = pts_pkg::TICKS_PER_SEC
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // One-cycle pulse once per second.
  output logic tick
);

  // The counter must hold the count and a tick needs at least two cycles.
  if (TICKS < 2 || TICKS > (2 ** pts_pkg::TICK_W)) begin : g_check
    $error("TICKS is out of the range the counter can serve.");
  end

  localparam logic [pts_pkg::TICK_W-1:0] LAST = (pts_pkg::TICK_W)'(TICKS - 1);

  pts_pkg::pts_tick_state_type s;
  pts_pkg::pts_tick_state_type next_s;

  // The counter wraps at the last cycle of each second and pulses tick there.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == LAST) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 1'b1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : pts_tick

// >>> test/pts_time_switch_sva.sv
// Checker of the APB answers and output timing of the periodic time switch.
`timescale 1ns/1ns
module pts_chk #(
  parameter int TICKS = 8
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pts_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Time switch output.
  input wire logic switch_out
);
  logic setup;
  logic done;
  logic en_q;
  logic [31:0] dur_q;
  logic [31:0] per_q;
  logic [31:0] hi_cnt;
  // A setup cycle and an accepted write as seen at the ports.
  assign setup = psel && !penable && ce;
  assign done = psel && penable && pready && pwrite && !pslverr && ce;
  // Shadow of enable and spans, and the length of the current high phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      dur_q <= 32'h3;
      per_q <= 32'h3;
      hi_cnt <= 32'h0;
    end else begin
      if (done && paddr == 8'h00) en_q <= pwdata[0];
      if (done && paddr == 8'h0C) dur_q <= pwdata;
      if (done && paddr == 8'h10) per_q <= pwdata;
      hi_cnt <= switch_out ? hi_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Longer properties are named so that each label line stays short.
  property p_ro_write;
    setup && pwrite && paddr inside {8'h14, 8'h18, 8'h1C} |=> pslverr;
  endproperty
  property p_sod_range;
    setup && pwrite && paddr == 8'h08 && pwdata > pts_pkg::LAST_SOD |=> pslverr;
  endproperty
  property p_span_range;
    setup && pwrite && (paddr == 8'h0C || paddr == 8'h10) &&
      (pwdata < pts_pkg::MIN_SPAN || pwdata > pts_pkg::MAX_SPAN) |=> pslverr;
  endproperty
  property p_high_len;
    $fell(switch_out) && en_q && dur_q < per_q |-> hi_cnt == dur_q * TICKS;
  endproperty
  a_ready_next: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_bad_addr: assert property (setup && paddr > 8'h24 |=> pslverr)
    else $error("unmapped access not refused");
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write not refused");
  a_sod_range: assert property (p_sod_range)
    else $error("time of day out of range accepted");
  a_span_range: assert property (p_span_range)
    else $error("span out of range accepted");
  a_high_len: assert property (p_high_len)
    else $error("high phase length wrong");
  a_off_low: assert property (!en_q && !$past(en_q, 4) |-> !switch_out)
    else $error("output high while disabled");
  c_rise: cover property ($rose(switch_out));
  c_fall: cover property ($fell(switch_out) && en_q);
  c_err: cover property (pready && pslverr);
endmodule : pts_chk
bind pts_time_switch pts_chk #(.TICKS(TICKS)) pts_chk_i (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_out(switch_out));

// >>> test/tb_top.sv
// Self-checking testbench of the periodic time switch.
`timescale 1ns/1ns
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic switch_out;
  int fails = 0;
  int n_tests = 0;
  // Clock of 4 ns period.
  always #2 pclk = ~pclk;
  pts_time_switch #(.TICKS(8)) pts_time_switch_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_out(switch_out));
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data and error flag are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fails++;
      close_out();
    end
  endtask : apb
  // Counts edges until the output shows the given level.
  task automatic wait_sw(input logic v, output int n);
    for (n = 0; n < 400 && switch_out !== v; n++) @(posedge pclk);
    if (n == 400) begin
      fails++;
      close_out();
    end
  endtask : wait_sw
  // Settings after reset.
  task automatic t_reset;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(0, 8'h0C, 0);
    chk(rd, 3);
    apb(0, 8'h14, 0);
    chk(rd, 0);
  endtask : t_reset
  // Refused and boundary accesses.
  task automatic t_refuse;
    logic [7:0] ta[8] = '{8'h28, 8'h14, 8'h08, 8'h04, 8'h04, 8'h0C, 8'h10, 8'h10};
    logic [31:0] td[8] = '{0, 1, 32'h15180, 32'h8EAD, 32'h8EAC, 2, 32'h83D601, 32'h83D600};
    logic te[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 8; k++) begin
      apb(1, ta[k], td[k]);
      chk(er, te[k]);
    end
    apb(0, 8'h0C, 0);
    chk(rd, 3);
    apb(0, 8'h04, 0);
    chk(rd, 32'h8EAC);
    apb(0, 8'h08, 0);
    chk(rd, 0);
  endtask : t_refuse
  // Start, high phase, low phase and next event readback.
  task automatic t_pulse;
    int n;
    apb(1, 8'h04, 0);
    apb(1, 8'h08, 5);
    apb(1, 8'h0C, 3);
    apb(1, 8'h10, 4);
    apb(0, 8'h1C, 0);
    chk(rd, 5);
    apb(1, 8'h20, 0);
    apb(1, 8'h24, 0);
    apb(1, 8'h00, 1);
    wait_sw(1, n);
    chk(n >= 28 && n <= 44, 1);
    wait_sw(0, n);
    chk(n, 24);
    wait_sw(1, n);
    chk(n, 8);
    apb(0, 8'h14, 0);
    chk(rd, 1);
    wait_sw(0, n);
    apb(0, 8'h1C, 0);
    chk(rd, 13);
    apb(0, 8'h18, 0);
    chk(rd, 0);
  endtask : t_pulse
  // Switching off during a high phase.
  task automatic t_disable;
    int n;
    wait_sw(1, n);
    apb(1, 8'h00, 0);
    repeat (2) @(posedge pclk);
    chk(switch_out, 0);
    repeat (46) @(posedge pclk);
    chk(switch_out, 0);
  endtask : t_disable
  // Clock enable low freezes the calendar and its tick counter.
  task automatic t_freeze;
    logic [31:0] a;
    apb(0, 8'h24, 0);
    a = rd;
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    apb(0, 8'h24, 0);
    chk(rd - a <= 1, 1);
  endtask : t_freeze
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    t_pulse();
    t_disable();
    t_freeze();
    close_out();
  end
endmodule : tb_top
